//--- include/mocs_cfg.svh
// offsets, field positions, reset values and widths of the statistics block
`ifndef MOCS_CFG_SVH
`define MOCS_CFG_SVH

// ---------------------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------------------
`define MOCS_OFF_GOOD_TX_OCTETS_LOW 16'h0409_0
`define MOCS_OFF_GOOD_TX_OCTETS_HIGH 16'h0409_4
`define MOCS_OFF_RX_NO_BUFFER_COUNT 16'h040a_0
`define MOCS_OFF_RX_UNDERSIZE_COUNT 16'h040a_4
`define MOCS_OFF_RX_FRAGMENT_COUNT 16'h040a_8
`define MOCS_OFF_RX_OVERSIZE_COUNT 16'h040a_c
`define MOCS_OFF_RX_JABBER_COUNT 16'h040b_0
`define MOCS_OFF_MGMT_RX_COUNT 16'h040b_4
`define MOCS_OFF_MGMT_DROPPED_COUNT 16'h040b_8
`define MOCS_OFF_MGMT_TX_COUNT 16'h040b_c
`define MOCS_OFF_TOTAL_RX_OCTETS_LOW 16'h040c_0
`define MOCS_OFF_TOTAL_RX_OCTETS_HIGH 16'h040c_4
`define MOCS_OFF_TOTAL_TX_OCTETS_LOW 16'h040c_8
`define MOCS_OFF_TOTAL_TX_OCTETS_HIGH 16'h040c_c
`define MOCS_OFF_CONTROL 16'h0410_0

// ---------------------------------------------------------------------------
// control register fields and reset values
// ---------------------------------------------------------------------------
`define MOCS_CTRL_RX_ENABLE_BIT 0
`define MOCS_CTRL_TX_ENABLE_BIT 1
`define MOCS_CTRL_LONG_PACKET_ENABLE_BIT 2
`define MOCS_CTRL_RESET 3'h0
`define MOCS_COUNT_RESET 32'h0000_0000
`define MOCS_OCTET_RESET 64'h0000_0000_0000_0000

// ---------------------------------------------------------------------------
// frame length limits, in octets from destination address through fcs
// ---------------------------------------------------------------------------
`define MOCS_LEN_W 16
`define MOCS_MIN_FRAME 16'h0040
`define MOCS_MAX_FRAME 16'h05f2
`define MOCS_OVERSIZE_LONG 16'h4000
`define MOCS_JABBER_LONG 16'h3fff
`define MOCS_MGMT_MAX 16'h00c8

// ---------------------------------------------------------------------------
// axi responses
// ---------------------------------------------------------------------------
`define MOCS_RESP_OKAY 2'h0
`define MOCS_RESP_SLVERR 2'h2

`endif

//--- include/mocs_pkg.sv
// types shared by the statistics counter block
`include "mocs_cfg.svh"
package mocs_pkg;

  // one transmit frame report, valid for one cycle at end of frame
  typedef struct packed {
    logic valid;
    logic error;
    logic partial;
    logic flow_ctrl;
    logic mgmt_src;
    logic [`MOCS_LEN_W-1:0] length;
  } mocs_tx_event_t;

  // one receive frame report, valid for one cycle at end of frame
  typedef struct packed {
    logic valid;
    logic fcs_ok;
    logic flow_ctrl;
    logic l2_error;
    logic addr_pass;
    logic no_buffer;
    logic fifo_room;
    logic mgmt_pass;
    logic mgmt_fifo_full;
    logic [`MOCS_LEN_W-1:0] length;
  } mocs_rx_event_t;

endpackage

//--- logic/mocs_stats_counters.sv
// mac statistics counter bank with axi4-lite register access
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps

// Functional notes
// - keep a 64-bit good transmitted octet count, read as two 32-bit halves
// - reading an upper half clears the whole 64-bit count
// - 64-bit octet counters stick at all ones instead of wrapping
// - good transmit octets: only sent frames of 64 bytes or more
// - good transmit octets exclude flow control frames
// - octets are counted from destination address through fcs inclusive
// - transmit counters advance only while transmit is enabled
// - receive counters advance only while receive is enabled
// - no-buffer count bumps per frame arriving with no host buffers
// - such a frame is still accepted when the receive fifo has room
// - no-buffer count ignores received flow control frames
// - oversize: filter-passing frame over 1522, or over 16384 in long mode
// - jabber: filter-passing frame with bad fcs over 1522, or over 16383 in long mode
// - management rx counts filter matches, drops included, not flow control or l2 errors
// - management drops: filter match lost to full fifo or over 200 bytes
// - management tx counts frames from management bus or alerting function
// - total rx octets add every received frame, broadcast rejects included
// - total tx octets add every sent frame, flow control included
// - total tx octets skip partially sent frames
module mocs_stats_counters
  import mocs_pkg::*;
#(
  parameter int ADDR_W = 16
) (
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire mocs_tx_event_t i_tx_event,
  input wire mocs_rx_event_t i_rx_event,
  input wire logic [ADDR_W-1:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [ADDR_W-1:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic o_rx_accept
);

  localparam int N_CNT = 8;
  localparam int N_OCT = 3;
  // indices of the 32-bit event counters
  localparam int C_NOBUF = 0;
  localparam int C_UNDER = 1;
  localparam int C_FRAG = 2;
  localparam int C_OVER = 3;
  localparam int C_JAB = 4;
  localparam int C_MRX = 5;
  localparam int C_MDROP = 6;
  localparam int C_MTX = 7;
  // indices of the 64-bit octet counters
  localparam int O_GOOD_TX = 0;
  localparam int O_TOTAL_RX = 1;
  localparam int O_TOTAL_TX = 2;

  // ---------------------------------------------------------------------------
  // control register
  // ---------------------------------------------------------------------------
  logic [2:0] control;
  logic rx_enable;
  logic tx_enable;
  logic long_packet_enable;
  assign rx_enable = control[`MOCS_CTRL_RX_ENABLE_BIT];
  assign tx_enable = control[`MOCS_CTRL_TX_ENABLE_BIT];
  assign long_packet_enable = control[`MOCS_CTRL_LONG_PACKET_ENABLE_BIT];

  // ---------------------------------------------------------------------------
  // frame classification
  // ---------------------------------------------------------------------------
  logic rx_take;
  logic tx_take;
  logic rx_short;
  logic rx_over;
  logic rx_jab_len;
  logic tx_sent;
  logic [N_CNT-1:0] inc;
  logic [`MOCS_LEN_W-1:0] add_len [N_OCT];

  always_comb begin
    rx_take = i_rx_event.valid && rx_enable;
    tx_take = i_tx_event.valid && tx_enable;
    tx_sent = tx_take && !i_tx_event.partial;
    rx_short = i_rx_event.length < `MOCS_MIN_FRAME;
    rx_over = long_packet_enable ? (i_rx_event.length > `MOCS_OVERSIZE_LONG)
                                 : (i_rx_event.length > `MOCS_MAX_FRAME);
    rx_jab_len = long_packet_enable ? (i_rx_event.length > `MOCS_JABBER_LONG)
                                    : (i_rx_event.length > `MOCS_MAX_FRAME);
    inc = '0;
    inc[C_NOBUF] = rx_take && i_rx_event.no_buffer && !i_rx_event.flow_ctrl;
    inc[C_UNDER] = rx_take && i_rx_event.addr_pass && rx_short && i_rx_event.fcs_ok;
    inc[C_FRAG] = rx_take && i_rx_event.addr_pass && rx_short && !i_rx_event.fcs_ok;
    inc[C_OVER] = rx_take && i_rx_event.addr_pass && rx_over;
    inc[C_JAB] = rx_take && i_rx_event.addr_pass && rx_jab_len && !i_rx_event.fcs_ok;
    inc[C_MRX] = rx_take && i_rx_event.mgmt_pass && !i_rx_event.flow_ctrl
                 && !i_rx_event.l2_error;
    inc[C_MDROP] = rx_take && i_rx_event.mgmt_pass
                   && (i_rx_event.mgmt_fifo_full || i_rx_event.length > `MOCS_MGMT_MAX);
    inc[C_MTX] = tx_sent && i_tx_event.mgmt_src;
    // lengths arrive already measured from destination address to fcs
    add_len[O_GOOD_TX] = '0;
    if (tx_sent && !i_tx_event.error && !i_tx_event.flow_ctrl
        && !(i_tx_event.length < `MOCS_MIN_FRAME)) begin
      add_len[O_GOOD_TX] = i_tx_event.length;
    end
    add_len[O_TOTAL_RX] = rx_take ? i_rx_event.length : '0;
    add_len[O_TOTAL_TX] = tx_sent ? i_tx_event.length : '0;
  end

  // ---------------------------------------------------------------------------
  // receive acceptance: host buffer shortage does not block the fifo
  // ---------------------------------------------------------------------------
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      o_rx_accept <= 1'b0;
    end else begin
      o_rx_accept <= rx_take && i_rx_event.fifo_room;
    end
  end

  // ---------------------------------------------------------------------------
  // axi4-lite write channel
  // ---------------------------------------------------------------------------
  logic wr_fire;
  logic [ADDR_W-1:0] wr_addr;
  logic wr_tx_low;
  assign wr_fire = o_awready && i_awvalid && o_wready && i_wvalid;
  assign wr_addr = i_awaddr;
  assign wr_tx_low = wr_fire && (wr_addr[15:2] == `MOCS_OFF_TOTAL_TX_OCTETS_LOW >> 2);

  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      o_awready <= 1'b0;
      o_wready <= 1'b0;
    end else begin
      // both ready pulse together once address and data are both offered
      o_awready <= i_awvalid && i_wvalid && !o_awready && !o_bvalid;
      o_wready <= i_awvalid && i_wvalid && !o_wready && !o_bvalid;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      o_bvalid <= 1'b0;
      o_bresp <= `MOCS_RESP_OKAY;
    end else if (wr_fire) begin
      o_bvalid <= 1'b1;
      // counter writes answer okay and are ignored, save the total tx low-half preset; only words outside 4090-40cc and control answer slverr
      o_bresp <= (wr_addr[15:2] >= (`MOCS_OFF_GOOD_TX_OCTETS_LOW >> 2)
                  && wr_addr[15:2] <= (`MOCS_OFF_TOTAL_TX_OCTETS_HIGH >> 2))
                 || wr_addr[15:2] == (`MOCS_OFF_CONTROL >> 2)
                 ? `MOCS_RESP_OKAY : `MOCS_RESP_SLVERR;
    end else if (i_bready) begin
      o_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      control <= `MOCS_CTRL_RESET;
    end else if (wr_fire && i_wstrb[0] && wr_addr[15:2] == (`MOCS_OFF_CONTROL >> 2)) begin
      control <= i_wdata[2:0];
    end
  end

  // ---------------------------------------------------------------------------
  // axi4-lite read channel
  // ---------------------------------------------------------------------------
  logic rd_fire;
  logic [13:0] rd_word;
  logic [N_OCT-1:0] clr_oct;
  logic [31:0] rd_mux;
  logic rd_hit;
  logic [31:0] cnt_q [N_CNT];
  logic [63:0] oct_q [N_OCT];
  assign rd_fire = o_arready && i_arvalid;
  assign rd_word = i_araddr[15:2];

  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_hit = 1'b1;
    clr_oct = '0;
    case (rd_word)
      `MOCS_OFF_GOOD_TX_OCTETS_LOW >> 2: rd_mux = oct_q[O_GOOD_TX][31:0];
      `MOCS_OFF_GOOD_TX_OCTETS_HIGH >> 2: begin
        rd_mux = oct_q[O_GOOD_TX][63:32];
        clr_oct[O_GOOD_TX] = rd_fire;
      end
      `MOCS_OFF_RX_NO_BUFFER_COUNT >> 2: rd_mux = cnt_q[C_NOBUF];
      `MOCS_OFF_RX_UNDERSIZE_COUNT >> 2: rd_mux = cnt_q[C_UNDER];
      `MOCS_OFF_RX_FRAGMENT_COUNT >> 2: rd_mux = cnt_q[C_FRAG];
      `MOCS_OFF_RX_OVERSIZE_COUNT >> 2: rd_mux = cnt_q[C_OVER];
      `MOCS_OFF_RX_JABBER_COUNT >> 2: rd_mux = cnt_q[C_JAB];
      `MOCS_OFF_MGMT_RX_COUNT >> 2: rd_mux = cnt_q[C_MRX];
      `MOCS_OFF_MGMT_DROPPED_COUNT >> 2: rd_mux = cnt_q[C_MDROP];
      `MOCS_OFF_MGMT_TX_COUNT >> 2: rd_mux = cnt_q[C_MTX];
      `MOCS_OFF_TOTAL_RX_OCTETS_LOW >> 2: rd_mux = oct_q[O_TOTAL_RX][31:0];
      `MOCS_OFF_TOTAL_RX_OCTETS_HIGH >> 2: begin
        rd_mux = oct_q[O_TOTAL_RX][63:32];
        clr_oct[O_TOTAL_RX] = rd_fire;
      end
      `MOCS_OFF_TOTAL_TX_OCTETS_LOW >> 2: rd_mux = oct_q[O_TOTAL_TX][31:0];
      `MOCS_OFF_TOTAL_TX_OCTETS_HIGH >> 2: begin
        rd_mux = oct_q[O_TOTAL_TX][63:32];
        clr_oct[O_TOTAL_TX] = rd_fire;
      end
      `MOCS_OFF_CONTROL >> 2: rd_mux = {29'h0, control};
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      o_arready <= 1'b0;
    end else begin
      o_arready <= i_arvalid && !o_arready && !o_rvalid;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      o_rvalid <= 1'b0;
      o_rdata <= 32'h0000_0000;
      o_rresp <= `MOCS_RESP_OKAY;
    end else if (rd_fire) begin
      // halves are separate words; no wide access exists on this bus
      o_rvalid <= 1'b1;
      o_rdata <= rd_mux;
      o_rresp <= rd_hit ? `MOCS_RESP_OKAY : `MOCS_RESP_SLVERR;
    end else if (i_rready) begin
      o_rvalid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // 32-bit event counters, sticking at all ones
  // ---------------------------------------------------------------------------
  // these never clear on read; software takes differences between samples
  for (genvar g = 0; g < N_CNT; g++) begin : g_cnt
    mocs_sat_counter #(
      .WIDTH(32)
    ) i_mocs_sat_counter (
      .i_clock(i_clock),
      .i_rstn(i_rstn),
      .i_inc(inc[g]),
      .o_count(cnt_q[g])
    );
  end

  // ---------------------------------------------------------------------------
  // 64-bit octet counters
  // ---------------------------------------------------------------------------
  // only the total transmit counter takes a software preset of its low half
  for (genvar g = 0; g < N_OCT; g++) begin : g_oct
    mocs_octet_counter #(
      .LEN_W(`MOCS_LEN_W)
    ) i_mocs_octet_counter (
      .i_clock(i_clock),
      .i_rstn(i_rstn),
      .i_clear(clr_oct[g]),
      .i_add(add_len[g]),
      .i_preset(wr_tx_low && (g == O_TOTAL_TX)),
      .i_wstrb(i_wstrb),
      .i_wdata(i_wdata),
      .o_count(oct_q[g])
    );
  end

endmodule // mocs_stats_counters

// ---------------------------------------------------------------------------
// saturating event counter
// ---------------------------------------------------------------------------
module mocs_sat_counter
  import mocs_pkg::*;
#(
  parameter int WIDTH = 32
) (
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire logic i_inc,
  output logic [WIDTH-1:0] o_count
);

  // sticking at all ones keeps a busy link from reading as a quiet one
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      o_count <= WIDTH'(`MOCS_COUNT_RESET);
    end else if (i_inc && o_count != {WIDTH{1'b1}}) begin
      o_count <= o_count + WIDTH'(1);
    end
  end

endmodule // mocs_sat_counter

// ---------------------------------------------------------------------------
// 64-bit octet counter, cleared by a high-half read, sticking at all ones
// ---------------------------------------------------------------------------
module mocs_octet_counter
  import mocs_pkg::*;
#(
  parameter int LEN_W = 16
) (
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire logic i_clear,
  input wire logic [LEN_W-1:0] i_add,
  input wire logic i_preset,
  input wire logic [3:0] i_wstrb,
  input wire logic [31:0] i_wdata,
  output logic [63:0] o_count
);

  logic [63:0] base;
  logic [64:0] sum;

  always_comb begin
    // a clearing read keeps the octets of a frame ending in the same cycle
    base = i_clear ? 64'h0000_0000_0000_0000 : o_count;
    sum = {1'b0, base} + 65'(i_add);
  end

  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      o_count <= `MOCS_OCTET_RESET;
    end else if (i_preset) begin
      // software preset of the low half; it overrides a same-cycle frame
      for (int b = 0; b < 4; b++) begin
        if (i_wstrb[b]) begin
          o_count[b*8 +: 8] <= i_wdata[b*8 +: 8];
        end
      end
    end else begin
      // carry out of bit 63 means the count would wrap: hold at all ones
      o_count <= sum[64] ? 64'hffff_ffff_ffff_ffff : sum[63:0];
    end
  end

endmodule // mocs_octet_counter

//--- verification/mocs_stats_properties.sv
// concurrent checks on the statistics bank register bus and accept pulse
`timescale 1ns/1ps
module mocs_stats_checker
  import mocs_pkg::*;
#(
  parameter int ADDR_W = 16
) (
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire mocs_rx_event_t i_rx_event,
  input wire logic i_awvalid,
  input wire logic o_awready,
  input wire logic i_wvalid,
  input wire logic o_wready,
  input wire logic [1:0] o_bresp,
  input wire logic o_bvalid,
  input wire logic i_bready,
  input wire logic [ADDR_W-1:0] i_araddr,
  input wire logic i_arvalid,
  input wire logic o_arready,
  input wire logic [31:0] o_rdata,
  input wire logic [1:0] o_rresp,
  input wire logic o_rvalid,
  input wire logic i_rready,
  input wire logic o_rx_accept
);
  // ----
  // helpers
  // ----
  wire logic hit = i_arvalid && o_arready;
  wire logic rmap = (i_araddr == 16'h4100) || (i_araddr[1:0] == 2'b00
    && i_araddr inside {[16'h4090:16'h4094], [16'h40a0:16'h40cc]});
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rstn);

  aw_pair_a: assert property (o_awready |-> i_awvalid && i_wvalid && o_wready)
    else $error("write address taken without its data");
  wr_resp_a: assert property (o_awready && i_awvalid |=> o_bvalid)
    else $error("write response missing");
  bresp_hold_a: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
    else $error("write response dropped early");
  ar_pulse_a: assert property (o_arready |=> !o_arready)
    else $error("read address ready held too long");
  rd_answer_a: assert property (hit |=> o_rvalid)
    else $error("read data missing after address");
  rdata_hold_a: assert property (o_rvalid && !i_rready |=> $stable(o_rdata) && o_rvalid)
    else $error("read data changed while waiting");
  unmapped_rd_a: assert property (hit && !rmap |=> o_rresp == 2'h2 && o_rdata == 32'h0)
    else $error("unmapped read not refused");
  mapped_rd_a: assert property (hit && rmap |=> o_rresp == 2'h0)
    else $error("mapped read refused");
  rx_accept_a: assert property (o_rx_accept |-> $past(i_rx_event.valid && i_rx_event.fifo_room))
    else $error("accept without a frame that fits");
  rx_refuse_a: assert property (i_rx_event.valid && !i_rx_event.fifo_room |=> !o_rx_accept)
    else $error("accept with no fifo room");

  wr_done_c: cover property (o_bvalid && i_bready);
  hi_read_c: cover property (hit && i_araddr == 16'h40c4);
  accept_c: cover property (o_rx_accept);
endmodule // mocs_stats_checker

bind mocs_stats_counters mocs_stats_checker #(.ADDR_W(ADDR_W)) i_mocs_stats_checker (
  .i_clock(i_clock), .i_rstn(i_rstn), .i_rx_event(i_rx_event), .i_awvalid(i_awvalid),
  .o_awready(o_awready), .i_wvalid(i_wvalid), .o_wready(o_wready), .o_bresp(o_bresp),
  .o_bvalid(o_bvalid), .i_bready(i_bready), .i_araddr(i_araddr), .i_arvalid(i_arvalid),
  .o_arready(o_arready), .o_rdata(o_rdata), .o_rresp(o_rresp), .o_rvalid(o_rvalid),
  .i_rready(i_rready), .o_rx_accept(o_rx_accept));

//--- verification/tb_top.sv
// self-checking bench for the statistics counter bank
`timescale 1ns/1ps
module tb_top;
  import mocs_pkg::*;
  logic i_clock, i_rstn, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_rx_accept;
  logic [1:0] o_bresp, o_rresp;
  logic [15:0] i_awaddr, i_araddr;
  logic [31:0] i_wdata, o_rdata;
  logic [3:0] i_wstrb;
  mocs_tx_event_t i_tx_event;
  mocs_rx_event_t i_rx_event;
  logic [33:0] exp_q[$];
  logic [63:0] gtx, ttx, trx;
  logic [2:0] ctl;
  int err_count, n_compared;

  mocs_stats_counters i_mocs_stats_counters (
    .i_clock(i_clock), .i_rstn(i_rstn), .i_tx_event(i_tx_event), .i_rx_event(i_rx_event),
    .i_awaddr(i_awaddr), .i_awvalid(i_awvalid), .o_awready(o_awready), .i_wdata(i_wdata),
    .i_wstrb(i_wstrb), .i_wvalid(i_wvalid), .o_wready(o_wready), .o_bresp(o_bresp),
    .o_bvalid(o_bvalid), .i_bready(i_bready), .i_araddr(i_araddr), .i_arvalid(i_arvalid),
    .o_arready(o_arready), .o_rdata(o_rdata), .o_rresp(o_rresp), .o_rvalid(o_rvalid),
    .i_rready(i_rready), .o_rx_accept(o_rx_accept));

  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end

  // ----
  // checking and bus tasks
  // ----
  task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic step(inout int n);
    @(posedge i_clock);
    n++;
    if (n > 40) begin
      err_count++;
      report_and_stop();
    end
  endtask

  // ready lines stay high, which keeps the tasks free of same-step reassignment
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    int n;
    n = 0;
    i_awaddr <= a;
    i_wdata <= d;
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    do begin
      step(n);
      if (o_awready === 1'b1) i_awvalid <= 1'b0;
      if (o_wready === 1'b1) i_wvalid <= 1'b0;
    end while (o_bvalid !== 1'b1);
  endtask

  task automatic rd(input logic [15:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
    int n;
    n = 0;
    exp_q.push_back({r, d});
    i_araddr <= a;
    i_arvalid <= 1'b1;
    do begin
      step(n);
      if (o_arready === 1'b1) i_arvalid <= 1'b0;
    end while (o_rvalid !== 1'b1);
  endtask

  task automatic rd64(input logic [15:0] a, inout logic [63:0] v);
    rd(a, v[31:0]);
    rd(a + 16'h0004, v[63:32]);
    v = '0;
  endtask

  task automatic setc(input logic [2:0] c);
    wr(16'h4100, {29'h0, c});
    ctl = c;
  endtask

  // f: error, partial, flow control, management source
  task automatic tx(input logic [15:0] l, input logic [3:0] f);
    i_tx_event <= {1'b1, f, l};
    if (ctl[1] && !f[2]) begin
      ttx += l;
      if (!f[3] && !f[1] && l >= 16'h0040) gtx += l;
    end
    @(posedge i_clock);
    i_tx_event <= '0;
    @(posedge i_clock);
  endtask

  // f: fcs ok, flow, l2 error, addr pass, no buffer, room, mgmt pass, mgmt full
  task automatic rx(input logic [15:0] l, input logic [7:0] f);
    i_rx_event <= {1'b1, f, l};
    if (ctl[0]) trx += l;
    @(posedge i_clock);
    i_rx_event <= '0;
    @(posedge i_clock);
    chk({33'h0, o_rx_accept}, {33'h0, ctl[0] && f[2]});
  endtask

  always @(posedge i_clock) begin
    if (i_rstn && o_rvalid === 1'b1 && i_rready) begin
      if (exp_q.size() == 0) chk(34'h0, 34'h1);
      else chk({o_rresp, o_rdata}, exp_q.pop_front());
    end
  end

  // ----
  // main sequence
  // ----
  initial begin
    {i_rstn, i_awvalid, i_wvalid, i_arvalid, i_tx_event, i_rx_event} = '0;
    {i_awaddr, i_araddr, i_wdata, gtx, ttx, trx, ctl} = '0;
    {i_bready, i_rready, i_wstrb} = 6'h3f;
    err_count = 0;
    n_compared = 0;
    void'($urandom(32'hdca9_1d25));
    repeat (8) @(posedge i_clock);
    i_rstn <= 1'b1;
    @(posedge i_clock);
    for (int a = 16'h4090; a <= 16'h40cc; a += 4)
      if (a != 16'h4098 && a != 16'h409c) rd(16'(a), 32'h0);
    rd(16'h4100, 32'h0);
    rd(16'h4200, 32'h0, 2'h2);
    setc(3'h3);
    for (int i = 0; i < 4; i++) tx(16'h0040 + 16'($urandom_range(1400)), 4'h0);
    tx(16'h003f, 4'h0);
    tx(16'h0040, 4'h2);
    tx(16'h00c8, 4'h4);
    tx(16'h0050, 4'h8);
    tx(16'h005a, 4'h1);
    rd(16'h4090, gtx[31:0]);
    rd64(16'h4090, gtx);
    rd(16'h4090, 32'h0);
    rd64(16'h40c8, ttx);
    rx(16'h0064, 8'b1001_1100);
    rx(16'h0040, 8'b1101_1100);
    rx(16'h003f, 8'b1001_0100);
    rx(16'h003f, 8'b0001_0100);
    rx(16'h05f3, 8'b1001_0100);
    rx(16'h05f3, 8'b0001_0100);
    rx(16'h05f2, 8'b0001_0100);
    rx(16'h003f, 8'b1000_0100);
    rx(16'h0064, 8'b1001_0110);
    rx(16'h0064, 8'b1001_0111);
    rx(16'h00c9, 8'b1001_0110);
    rx(16'h0064, 8'b1101_0110);
    rx(16'h0064, 8'b1011_0010);
    setc(3'h7);
    rx(16'h4000, 8'b0001_0100);
    rx(16'h4001, 8'b1001_0100);
    setc(3'h2);
    rx(16'h003f, 8'b1001_0100);
    setc(3'h1);
    tx(16'h0064, 4'h0);
    wr(16'h40a4, 32'hffff_ffff);
    rd(16'h40a0, 32'h1);
    rd(16'h40a4, 32'h1);
    rd(16'h40a8, 32'h1);
    rd(16'h40ac, 32'h3);
    rd(16'h40b0, 32'h2);
    rd(16'h40b4, 32'h3);
    rd(16'h40b8, 32'h2);
    rd(16'h40bc, 32'h1);
    rd64(16'h40c0, trx);
    rd64(16'h40c8, ttx);
    wr(16'h40c8, 32'h1234_5678);
    rd(16'h40c8, 32'h1234_5678);
    repeat (3) @(posedge i_clock);
    report_and_stop();
  end
endmodule // tb_top
